/* File: inc/rpc_pkg.sv */
// rpc_pkg: constants and types shared by the reset and power-on controller
// assumes a 10 MHz system clock; all slow rates are derived as enable pulses
package rpc_pkg;
  localparam int unsigned CLK_HZ           = 10000000;
  // power stabilization wait, typical
  localparam int unsigned PWR_STAB_US      = 4600;
  localparam int unsigned PWR_STAB_CYC     = (PWR_STAB_US * (CLK_HZ / 1000000));
  // debounce low time for the reset pin
  localparam int unsigned DEBOUNCE_US      = 8000;
  localparam int unsigned DEBOUNCE_CYC     = (DEBOUNCE_US * (CLK_HZ / 1000000));
  // slow oscillator nominal rate, used to make the slow tick
  localparam int unsigned SLOW_OSC_HZ      = 16000;
  localparam int unsigned SLOW_TICK_CYC    = CLK_HZ / SLOW_OSC_HZ;
  // wide enough for the 8 ms debounce count at the system rate
  localparam int unsigned CNT_W            = 17;
  // clock stabilization counts
  localparam logic [11:0] CLK_STAB_FAST    = 12'h800;
  localparam logic [2:0]  CLK_STAB_SLOW    = 3'h5;
  // watchdog
  localparam logic [7:0]  WDT_CLEAR_CODE   = 8'h5a;
  localparam logic [7:0]  WDT_OVF_LAST     = 8'hff;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;

  typedef enum logic [1:0] {
    RPC_WDT_DISABLED = 2'h0,
    RPC_WDT_ENABLED  = 2'h1,
    RPC_WDT_ALWAYS   = 2'h2
  } rpc_wdt_mode_t;

  typedef enum logic [1:0] {
    RPC_PIN_RST_DEBOUNCE = 2'h0,
    RPC_PIN_RST_DIRECT   = 2'h1,
    RPC_PIN_GPIO         = 2'h2
  } rpc_pin_mode_t;

  typedef enum logic [2:0] {
    RPC_CLK_FAST_OSC  = 3'h0,
    RPC_CLK_FAST_RTC  = 3'h1,
    RPC_CLK_HS_XTAL   = 3'h2,
    RPC_CLK_STD_XTAL  = 3'h3,
    RPC_CLK_EXT_INPUT = 3'h4
  } rpc_clk_src_t;

  typedef enum logic [5:0] {
    RPC_ST_HOLD     = 6'b000001,
    RPC_ST_PWR_STAB = 6'b000010,
    RPC_ST_LOAD_CFG = 6'b000100,
    RPC_ST_CLK_STAB = 6'b001000,
    RPC_ST_RUN      = 6'b010000,
    RPC_ST_SOFT     = 6'b100000
  } rpc_state_t;
endpackage

/* File: logic/rpc_watchdog.sv */
// rpc_watchdog: 256-tick watchdog with prescaled slow-oscillator tick
// assumes i_slow_tick is a one-cycle enable at the slow oscillator rate
`timescale 1ns/10ps
module rpc_watchdog (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_sys_reset,
  input  wire logic       i_slow_tick,
  input  wire logic [1:0] i_prescale_sel,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_low_power,
  input  wire logic       i_clear_wr,
  input  wire logic [7:0] i_clear_data,
  output logic            o_expire
);
  logic [4:0] pre_q;
  logic [4:0] pre_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       expire_q;
  // span of 32 needs a sixth bit before the last count is taken
  wire  [5:0] pre_span = 6'h04 << i_prescale_sel;
  wire  [4:0] pre_last = 5'(pre_span - 6'h01);
  wire        counting = (i_mode == rpc_pkg::RPC_WDT_ALWAYS) ||
                         ((i_mode == rpc_pkg::RPC_WDT_ENABLED) && !i_low_power);
  wire        clear_hit = i_clear_wr && (i_clear_data == rpc_pkg::WDT_CLEAR_CODE);
  wire        wdt_tick  = counting && i_slow_tick && (pre_q == pre_last);

  assign pre_d = (!counting || clear_hit) ? 5'h00 :
                 (i_slow_tick ? ((pre_q == pre_last) ? 5'h00 : pre_q + 5'h01) : pre_q);
  assign cnt_d = (!counting || clear_hit) ? 8'h00 : (wdt_tick ? cnt_q + 8'h01 : cnt_q);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_sys_reset) begin
      pre_q    <= 5'h00;
      cnt_q    <= 8'h00;
      expire_q <= 1'b0;
    end else begin
      pre_q    <= pre_d;
      cnt_q    <= cnt_d;
      expire_q <= wdt_tick && (cnt_q == rpc_pkg::WDT_OVF_LAST) && !clear_hit;
    end
  end
  assign o_expire = expire_q;

  property p_clear_restarts;
    @(posedge i_clk_sys) disable iff (i_rst)
    clear_hit |=> (cnt_q == 8'h00) && (pre_q == 5'h00);
  endproperty
  a_clear_restarts: assert property (p_clear_restarts) else $error("clear write ignored");
endmodule

/* File: logic/rpc_reset_ctrl.sv */
// rpc_reset_ctrl: reset and power-on controller with sequencer, pin reset, watchdog
// assumes config straps are static; pin and detector inputs are asynchronous
// Summary of operation
// - reset requests come from low supply, watchdog, reset pin and software.
// - hardware resets run the power-on sequence; software reset skips it.
// - after reset, registers reset and fetch starts at address zero.
// - sequence starts on release: power stabilization, then clock stabilization.
// - power stabilization waits 4.6 ms before loading the clock choice.
// - after power wait, clock source choice is loaded and enabled.
// - clock stabilization counts 2048 source clocks and 5 slow clocks.
// - low supply detector output, at or below 1.8 V, requests reset.
// - firmware writes 0x5a to watchdog clear; this restarts the timer.
// - watchdog resets only when its timer expires uncleared.
// - always mode counts in normal, stop and idle modes.
// - enabled mode counts only in normal; disabled never counts.
// - watchdog tick is slow oscillator divided by 4, 8, 16 or 32.
// - shared pin: reset with debounce, reset without debounce, or gpio.
// - clock source is one of five options.
// - code protection option is taken from power-on configuration.
// - debounced pin resets only after 8 ms continuous low.
// - software reset needs two consecutive sets of the request bit.
// - watchdog overflow equals 256 prescaled slow ticks.
// - readable cause flags for low supply, watchdog and reset pin.
`timescale 1ns/10ps
module rpc_reset_ctrl #(
  parameter int unsigned PWR_STAB_CYC = rpc_pkg::PWR_STAB_CYC,
  parameter int unsigned DEBOUNCE_CYC = rpc_pkg::DEBOUNCE_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_low_supply_detect_level,
  input  wire logic        i_shared_reset_gpio_pin,
  input  wire logic        i_fast_clk_tick,
  input  wire logic        i_low_power,
  input  wire logic        i_watchdog_clear_wr,
  input  wire logic [7:0]  i_watchdog_clear_data,
  input  wire logic        i_soft_reset_wr,
  input  wire logic        i_soft_reset_request_bit,
  input  wire logic [2:0]  i_cfg_clk_src,
  input  wire logic [1:0]  i_cfg_pin_mode,
  input  wire logic [1:0]  i_cfg_wdt_mode,
  input  wire logic [1:0]  i_cfg_wdt_prescale,
  input  wire logic        i_cfg_code_protect,
  output logic             o_cpu_reset,
  output logic [15:0]      o_fetch_addr,
  output logic             o_reg_init,
  output logic [2:0]       o_clk_src,
  output logic             o_clk_src_en,
  output logic             o_code_protect,
  output logic             o_cause_low_supply,
  output logic             o_cause_watchdog,
  output logic             o_cause_pin,
  output logic             o_cause_soft,
  output logic             o_gpio_mode,
  output logic             o_gpio_in
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous pins
  logic [1:0] lvd_sync_q;
  logic [1:0] pin_sync_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lvd_sync_q <= 2'h0;
      pin_sync_q <= 2'h3;
    end else begin
      lvd_sync_q <= {lvd_sync_q[0], i_low_supply_detect_level};
      pin_sync_q <= {pin_sync_q[0], i_shared_reset_gpio_pin};
    end
  end
  wire lvd_req = lvd_sync_q[1];
  wire pin_low = !pin_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // slow oscillator tick from divider
  logic [rpc_pkg::CNT_W-1:0] slow_div_q;
  wire slow_tick = (slow_div_q == rpc_pkg::CNT_W'(rpc_pkg::SLOW_TICK_CYC - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || slow_tick) begin
      slow_div_q <= '0;
    end else begin
      slow_div_q <= slow_div_q + rpc_pkg::CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pin: direct, debounced or gpio
  logic [rpc_pkg::CNT_W-1:0] deb_q;
  wire pin_is_rst = (i_cfg_pin_mode != rpc_pkg::RPC_PIN_GPIO);
  wire deb_mode   = (i_cfg_pin_mode == rpc_pkg::RPC_PIN_RST_DEBOUNCE);
  wire deb_done   = (deb_q == rpc_pkg::CNT_W'(DEBOUNCE_CYC - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !pin_low) begin
      deb_q <= '0; // short pulse forgets its progress
    end else if (!deb_done) begin
      deb_q <= deb_q + rpc_pkg::CNT_W'(1);
    end
  end
  // once debounced, reset holds while the pin stays low
  wire pin_req = pin_is_rst && pin_low && (deb_mode ? deb_done : 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // software reset: two consecutive sets
  logic soft_armed_q;
  logic soft_req_q;
  wire  soft_set = i_soft_reset_wr && i_soft_reset_request_bit;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || o_cpu_reset) begin
      soft_armed_q <= 1'b0;
      soft_req_q   <= 1'b0;
    end else if (i_soft_reset_wr) begin
      // a write of zero breaks the pair
      soft_armed_q <= soft_set && !soft_armed_q;
      soft_req_q   <= soft_set && soft_armed_q;
    end else begin
      soft_req_q   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  logic wdt_expire;
  rpc_watchdog u_wdt (
    .i_clk_sys      (i_clk_sys),
    .i_rst          (i_rst),
    .i_sys_reset    (o_cpu_reset),
    .i_slow_tick    (slow_tick),
    .i_prescale_sel (i_cfg_wdt_prescale),
    .i_mode         (i_cfg_wdt_mode),
    .i_low_power    (i_low_power),
    .i_clear_wr     (i_watchdog_clear_wr),
    .i_clear_data   (i_watchdog_clear_data),
    .o_expire       (wdt_expire)
  );

  wire hw_req = lvd_req || pin_req || wdt_expire;

  ////////////////////////////////////////////////////////////////////////////
  // power-on sequencer
  rpc_pkg::rpc_state_t st_q;
  rpc_pkg::rpc_state_t st_d;
  logic [rpc_pkg::CNT_W-1:0] seq_cnt_q;
  logic [11:0] fast_cnt_q;
  logic [2:0]  slow_cnt_q;
  wire pwr_done  = (seq_cnt_q == rpc_pkg::CNT_W'(PWR_STAB_CYC - 1));
  wire fast_done = (fast_cnt_q == rpc_pkg::CLK_STAB_FAST);
  wire slow_done = (slow_cnt_q == rpc_pkg::CLK_STAB_SLOW);

  always_comb begin
    st_d = st_q;
    case (st_q)
      rpc_pkg::RPC_ST_HOLD:     if (!hw_req) st_d = rpc_pkg::RPC_ST_PWR_STAB;
      rpc_pkg::RPC_ST_PWR_STAB: if (pwr_done) st_d = rpc_pkg::RPC_ST_LOAD_CFG;
      rpc_pkg::RPC_ST_LOAD_CFG: st_d = rpc_pkg::RPC_ST_CLK_STAB;
      rpc_pkg::RPC_ST_CLK_STAB: if (fast_done && slow_done) st_d = rpc_pkg::RPC_ST_RUN;
      rpc_pkg::RPC_ST_SOFT:     st_d = rpc_pkg::RPC_ST_RUN;
      rpc_pkg::RPC_ST_RUN:      if (soft_req_q) st_d = rpc_pkg::RPC_ST_SOFT;
      default:                  st_d = rpc_pkg::RPC_ST_HOLD;
    endcase
    if (hw_req) begin
      st_d = rpc_pkg::RPC_ST_HOLD;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= rpc_pkg::RPC_ST_HOLD;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || st_q != rpc_pkg::RPC_ST_PWR_STAB) begin
      seq_cnt_q <= '0;
    end else begin
      seq_cnt_q <= seq_cnt_q + rpc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || st_q != rpc_pkg::RPC_ST_CLK_STAB) begin
      fast_cnt_q <= 12'h000;
      slow_cnt_q <= 3'h0;
    end else begin
      if (i_fast_clk_tick && !fast_done) begin
        fast_cnt_q <= fast_cnt_q + 12'h001;
      end
      if (slow_tick && !slow_done) begin
        slow_cnt_q <= slow_cnt_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration load
  logic [2:0] clk_src_q;
  logic       clk_en_q;
  logic       protect_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clk_src_q <= rpc_pkg::RPC_CLK_FAST_OSC;
      clk_en_q  <= 1'b0;
      protect_q <= 1'b1;
    end else if (st_q == rpc_pkg::RPC_ST_LOAD_CFG) begin
      // out-of-range choice falls back to the internal oscillator
      clk_src_q <= (i_cfg_clk_src > rpc_pkg::RPC_CLK_EXT_INPUT) ?
                   rpc_pkg::RPC_CLK_FAST_OSC : i_cfg_clk_src;
      clk_en_q  <= 1'b1;
      protect_q <= i_cfg_code_protect;
    end else if (st_q == rpc_pkg::RPC_ST_HOLD) begin
      clk_en_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cause flags: latched on entry to hold, kept across the sequence
  logic cause_lvd_q;
  logic cause_wdt_q;
  logic cause_pin_q;
  logic cause_soft_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cause_lvd_q  <= 1'b0;
      cause_wdt_q  <= 1'b0;
      cause_pin_q  <= 1'b0;
      cause_soft_q <= 1'b0;
    end else if (hw_req && st_q != rpc_pkg::RPC_ST_HOLD) begin
      cause_lvd_q  <= lvd_req;
      cause_wdt_q  <= wdt_expire;
      cause_pin_q  <= pin_req;
      cause_soft_q <= 1'b0;
    end else if (soft_req_q && st_q == rpc_pkg::RPC_ST_RUN) begin
      cause_lvd_q  <= 1'b0;
      cause_wdt_q  <= 1'b0;
      cause_pin_q  <= 1'b0;
      cause_soft_q <= 1'b1;
    end else if (st_q == rpc_pkg::RPC_ST_HOLD) begin
      cause_lvd_q  <= cause_lvd_q | lvd_req;
      cause_wdt_q  <= cause_wdt_q | wdt_expire;
      cause_pin_q  <= cause_pin_q | pin_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic gpio_in_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gpio_in_q <= 1'b1;
    end else begin
      gpio_in_q <= pin_sync_q[1];
    end
  end

  assign o_cpu_reset        = (st_q != rpc_pkg::RPC_ST_RUN);
  assign o_reg_init         = o_cpu_reset;
  assign o_fetch_addr       = rpc_pkg::RESET_VECTOR;
  assign o_clk_src          = clk_src_q;
  assign o_clk_src_en       = clk_en_q;
  assign o_code_protect     = protect_q;
  assign o_cause_low_supply = cause_lvd_q;
  assign o_cause_watchdog   = cause_wdt_q;
  assign o_cause_pin        = cause_pin_q;
  assign o_cause_soft       = cause_soft_q;
  assign o_gpio_mode        = !pin_is_rst;
  assign o_gpio_in          = gpio_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // second set while the first one is still armed
  sequence s_soft_pair;
    soft_armed_q && soft_set && !o_cpu_reset;
  endsequence

  property p_soft_fires;
    @(posedge i_clk_sys) disable iff (i_rst)
    s_soft_pair |=> soft_req_q;
  endproperty
  a_soft_fires: assert property (p_soft_fires) else $error("second set ignored");

  property p_soft_skip;
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == rpc_pkg::RPC_ST_RUN && soft_req_q && !hw_req) |=>
      (st_q == rpc_pkg::RPC_ST_SOFT) ##1 (st_q == rpc_pkg::RPC_ST_RUN);
  endproperty
  a_soft_skip: assert property (p_soft_skip) else $error("soft reset not skipping");

  property p_soft_pair;
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(soft_req_q) |-> $past(soft_set) && $past(soft_armed_q);
  endproperty
  a_soft_pair: assert property (p_soft_pair) else $error("soft reset without pair");

  property p_hold_on_req;
    @(posedge i_clk_sys) disable iff (i_rst)
    hw_req |=> (st_q == rpc_pkg::RPC_ST_HOLD) && o_cpu_reset;
  endproperty
  a_hold_on_req: assert property (p_hold_on_req) else $error("request not holding cpu");

  property p_release_starts;
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == rpc_pkg::RPC_ST_HOLD && !hw_req) |=> (st_q == rpc_pkg::RPC_ST_PWR_STAB);
  endproperty
  a_release_starts: assert property (p_release_starts) else $error("sequence not started");

  property p_load_after_pwr;
    @(posedge i_clk_sys) disable iff (i_rst)
    (st_q == rpc_pkg::RPC_ST_PWR_STAB && pwr_done && !hw_req) |=>
      (st_q == rpc_pkg::RPC_ST_LOAD_CFG) ##1 clk_en_q;
  endproperty
  a_load_after_pwr: assert property (p_load_after_pwr) else $error("clock not loaded");

  property p_run_needs_stab;
    @(posedge i_clk_sys) disable iff (i_rst)
    ($past(st_q) == rpc_pkg::RPC_ST_CLK_STAB && st_q == rpc_pkg::RPC_ST_RUN) |->
      $past(fast_done) && $past(slow_done);
  endproperty
  a_run_needs_stab: assert property (p_run_needs_stab) else $error("early cpu release");

  property p_lvd_cause;
    @(posedge i_clk_sys) disable iff (i_rst)
    (lvd_req && st_q == rpc_pkg::RPC_ST_RUN) |=> cause_lvd_q;
  endproperty
  a_lvd_cause: assert property (p_lvd_cause) else $error("lvd cause missing");

  property p_pin_gpio;
    @(posedge i_clk_sys) disable iff (i_rst)
    (!pin_is_rst && pin_low && st_q == rpc_pkg::RPC_ST_RUN && !lvd_req && !wdt_expire &&
     !soft_req_q) |=> (st_q == rpc_pkg::RPC_ST_RUN);
  endproperty
  a_pin_gpio: assert property (p_pin_gpio) else $error("gpio pin caused reset");

  property p_pin_deb;
    @(posedge i_clk_sys) disable iff (i_rst)
    (deb_mode && pin_req) |-> deb_done && pin_low;
  endproperty
  a_pin_deb: assert property (p_pin_deb) else $error("pin reset before debounce");

  property p_deb_restart;
    @(posedge i_clk_sys) disable iff (i_rst)
    !pin_low |=> (deb_q == '0);
  endproperty
  a_deb_restart: assert property (p_deb_restart) else $error("debounce kept progress");

  property p_wdt_clr_reset;
    @(posedge i_clk_sys) disable iff (i_rst)
    wdt_expire |=> o_cpu_reset [*2];
  endproperty
  a_wdt_clr_reset: assert property (p_wdt_clr_reset) else $error("watchdog ignored");
endmodule

/* File: dv/rpc_cpu_model.sv */
// rpc_cpu_model: cpu core and firmware as seen by the reset controller
// assumes one system clock; the bench starts soft reset sequences by command
`timescale 1ns/10ps
module rpc_cpu_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_cpu_reset,
  input  wire logic       i_soft_go,
  input  wire logic       i_soft_break,
  output logic            o_fast_clk_tick,
  output logic            o_low_power,
  output logic            o_clear_wr,
  output logic [7:0]      o_clear_data,
  output logic            o_soft_wr,
  output logic            o_soft_bit
);
  logic       tick_q;
  logic [9:0] svc_q;
  logic [2:0] step_q;
  logic       brk_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tick_q <= 1'b0;
      svc_q  <= 10'h000;
      step_q <= 3'h0;
      brk_q  <= 1'b0;
    end else begin
      // selected source runs at half the system rate
      tick_q <= ~tick_q;
      svc_q  <= i_cpu_reset ? 10'h000 : svc_q + 10'h001;
      if (i_soft_go) begin
        step_q <= 3'h1;
        brk_q  <= i_soft_break;
      end else if (step_q != 3'h0) begin
        step_q <= (step_q == 3'h6) ? 3'h0 : step_q + 3'h1;
      end
    end
  end

  assign o_fast_clk_tick = tick_q;
  // firmware drops into idle or stop for long stretches
  assign o_low_power     = svc_q[9];
  // checkpoint write while running
  assign o_clear_wr      = (svc_q[7:0] == 8'hff);
  // data off the strobe is junk, not the last code
  assign o_clear_data    = o_clear_wr ? rpc_pkg::WDT_CLEAR_CODE : 8'ha5;
  // two sets with a gap; broken form follows one set with clears
  // so no armed set is left over for the next pair
  assign o_soft_wr       = (step_q == 3'h1) || (step_q == 3'h3) || (step_q == 3'h5 && brk_q);
  assign o_soft_bit      = o_soft_wr & ~(brk_q && step_q != 3'h1);
endmodule

/* File: dv/rpc_reset_ctrl_test.sv */
// rpc_reset_ctrl_test: self-checking bench for the reset and power-on controller
// assumes short stabilization parameters; firmware side is rpc_cpu_model
`timescale 1ns/10ps
module rpc_reset_ctrl_test;
  localparam int unsigned PWR     = 20;
  localparam int unsigned DEB     = 10;
  // fast tick every second cycle, slow tick every 625 cycles
  localparam int unsigned SEQ_MIN = PWR + 1 + 2 * 2048;
  localparam int unsigned SEQ_MAX = SEQ_MIN + 5 * 625 + 60;
  logic        clk_sys;
  logic        rst;
  logic        lvd;
  logic        pin;
  logic        soft_go;
  logic        soft_break;
  logic        cfg_cp;
  logic [2:0]  cfg_src;
  logic [1:0]  cfg_pin;
  logic [1:0]  cfg_wdt;
  logic [1:0]  cfg_pre;
  wire logic   tick, clr_wr, soft_wr, soft_bit, low_pwr;
  wire logic   cpu_rst, reg_init, clk_en, cp, c_lvd, c_wdt, c_pin, c_soft, gpio_mode, gpio_in;
  wire logic [7:0]  clr_data;
  wire logic [15:0] fetch;
  wire logic [2:0]  clk_src;
  int          err_count;
  int          checks;

  rpc_reset_ctrl #(.PWR_STAB_CYC(PWR), .DEBOUNCE_CYC(DEB)) i_dut (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_low_supply_detect_level(lvd),
    .i_shared_reset_gpio_pin(pin), .i_fast_clk_tick(tick), .i_low_power(low_pwr),
    .i_watchdog_clear_wr(clr_wr), .i_watchdog_clear_data(clr_data),
    .i_soft_reset_wr(soft_wr), .i_soft_reset_request_bit(soft_bit),
    .i_cfg_clk_src(cfg_src), .i_cfg_pin_mode(cfg_pin), .i_cfg_wdt_mode(cfg_wdt),
    .i_cfg_wdt_prescale(cfg_pre), .i_cfg_code_protect(cfg_cp),
    .o_cpu_reset(cpu_rst), .o_fetch_addr(fetch), .o_reg_init(reg_init),
    .o_clk_src(clk_src), .o_clk_src_en(clk_en), .o_code_protect(cp),
    .o_cause_low_supply(c_lvd), .o_cause_watchdog(c_wdt), .o_cause_pin(c_pin),
    .o_cause_soft(c_soft), .o_gpio_mode(gpio_mode), .o_gpio_in(gpio_in));

  rpc_cpu_model i_cpu (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_cpu_reset(cpu_rst), .i_soft_go(soft_go),
    .i_soft_break(soft_break), .o_fast_clk_tick(tick), .o_low_power(low_pwr),
    .o_clear_wr(clr_wr), .o_clear_data(clr_data), .o_soft_wr(soft_wr),
    .o_soft_bit(soft_bit));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // cycles until cpu reset reaches lvl; running out ends the run
  task automatic wait_level(input logic lvl, input int bound, output int n);
    n = 0;
    while (cpu_rst !== lvl) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > bound) begin
        err_count++;
        $display("ERROR %0t cpu reset wait ran out", $time);
        summarize();
      end
    end
  endtask

  task automatic hold_check(input logic lvl, input int cyc, output int bad);
    bad = 0;
    repeat (cyc) begin
      @(posedge clk_sys);
      #1;
      if (cpu_rst !== lvl) bad++;
    end
  endtask

  task automatic apply_reset(input logic [2:0] src, input logic [1:0] pm, input logic prot);
    int n;
    @(posedge clk_sys);
    rst     <= 1'b1;
    cfg_src <= src;
    cfg_pin <= pm;
    cfg_cp  <= prot;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wait_level(1'b0, SEQ_MAX, n);
    check(n >= SEQ_MIN, "cpu released before stabilization");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    for (int s = 0; s < 6; s++) begin
      cfg_wdt <= 2'(s % 3);
      cfg_pre <= 2'(s);
      apply_reset(3'(s), rpc_pkg::RPC_PIN_RST_DIRECT, s[0]);
      // choice above the last source falls back to the internal oscillator
      check(clk_src === ((s > 4) ? 3'h0 : 3'(s)) && clk_en === 1'b1, "clock source not loaded");
      check(cp === s[0], "code protect not loaded");
      check(fetch === 16'h0000 && reg_init === 1'b0, "bad start state");
    end
  endtask

  task automatic t_lvd;
    int n;
    int bad;
    @(posedge clk_sys) lvd <= 1'b1;
    wait_level(1'b1, 6, n);
    hold_check(1'b1, 100, bad);
    check(bad == 0, "cpu ran under low supply");
    check(reg_init === 1'b1 && clk_en === 1'b0, "clock or registers live in hold");
    check(c_lvd === 1'b1 && c_pin === 1'b0 && c_wdt === 1'b0, "low supply cause");
    @(posedge clk_sys) lvd <= 1'b0;
    repeat (200) @(posedge clk_sys);
    // a second dip mid-sequence must restart from power stabilization
    lvd <= 1'b1;
    repeat (10) @(posedge clk_sys);
    lvd <= 1'b0;
    wait_level(1'b0, SEQ_MAX + 10, n);
    check(n >= SEQ_MIN, "sequence not restarted");
  endtask

  task automatic t_pin_direct;
    int n;
    int bad;
    check(gpio_mode === 1'b0, "pin reported as gpio");
    @(posedge clk_sys) pin <= 1'b0;
    wait_level(1'b1, 6, n);
    hold_check(1'b1, 30, bad);
    check(bad == 0, "cpu ran with pin low");
    check(c_pin === 1'b1 && c_lvd === 1'b0, "pin cause");
    @(posedge clk_sys) pin <= 1'b1;
    wait_level(1'b0, SEQ_MAX + 10, n);
    check(n >= SEQ_MIN, "pin reset skipped the sequence");
  endtask

  task automatic t_debounce;
    int n;
    int bad;
    apply_reset(3'h2, rpc_pkg::RPC_PIN_RST_DEBOUNCE, 1'b0);
    @(posedge clk_sys) pin <= 1'b0;
    repeat (DEB - 3) @(posedge clk_sys);
    pin <= 1'b1;
    hold_check(1'b0, 30, bad);
    check(bad == 0, "short low pulse caused reset");
    @(posedge clk_sys) pin <= 1'b0;
    wait_level(1'b1, DEB + 10, n);
    check(n >= DEB, "debounced reset too early");
    check(c_pin === 1'b1 && c_lvd === 1'b0, "debounced pin cause");
    @(posedge clk_sys) pin <= 1'b1;
    wait_level(1'b0, SEQ_MAX + 10, n);
    check(n >= SEQ_MIN, "debounced reset skipped the sequence");
  endtask

  task automatic t_gpio_soft;
    int n;
    int bad;
    apply_reset(3'h4, rpc_pkg::RPC_PIN_GPIO, 1'b1);
    check(gpio_mode === 1'b1, "gpio mode not shown");
    @(posedge clk_sys) pin <= 1'b0;
    hold_check(1'b0, 30, bad);
    check(bad == 0 && gpio_in === 1'b0, "gpio pin caused reset");
    @(posedge clk_sys) pin <= 1'b1;
    soft_break <= 1'b1;
    soft_go    <= 1'b1;
    @(posedge clk_sys) soft_go <= 1'b0;
    hold_check(1'b0, 20, bad);
    check(bad == 0, "broken pair caused reset");
    @(posedge clk_sys) soft_break <= 1'b0;
    soft_go <= 1'b1;
    @(posedge clk_sys) soft_go <= 1'b0;
    wait_level(1'b1, 10, n);
    wait_level(1'b0, 6, n);
    check(n <= 3, "soft reset ran the sequence");
    check(c_soft === 1'b1 && c_pin === 1'b0 && c_lvd === 1'b0, "soft cause");
    check(fetch === 16'h0000 && clk_src === 3'h4, "soft restart state");
    check(c_wdt === 1'b0, "serviced watchdog fired");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count  = 0;
    checks     = 0;
    rst        = 1'b1;
    lvd        = 1'b0;
    pin        = 1'b1;
    soft_go    = 1'b0;
    soft_break = 1'b0;
    cfg_cp     = 1'b0;
    cfg_src    = 3'h0;
    cfg_pin    = rpc_pkg::RPC_PIN_RST_DIRECT;
    cfg_wdt    = rpc_pkg::RPC_WDT_ALWAYS;
    cfg_pre    = 2'h0;
    repeat (3) @(posedge clk_sys);
    t_power_on();
    t_lvd();
    t_pin_direct();
    t_debounce();
    t_gpio_soft();
    summarize();
  end
endmodule
